/* tb/dee_error_reevaluate_bit_region_tb.sv */
// dee_error_reevaluate_bit_region_tb.sv: self-checking bench for the error
// evaluation and region enable block; drives every port directly.
`timescale 1ns/1ps
module dee_error_reevaluate_bit_region_tb;
   reg clk, rst, reg_wr, reg_rd;
   reg [7:0] reg_addr, qmis, qrd, qwm;
   reg [31:0] reg_wdata, rgn_sel, mlo, mhi, t;
   reg [16:0] cset;
   reg [63:0] crd, cwm, pend, dena;
   wire [31:0] reg_rdata;
   wire [63:0] grd, gwm;
   wire [7:0] gqrd, gqwm;
   wire [1:0] rdone;
   wire pulse, irq;
   reg [31:0] en_lo [0:1], en_hi [0:1];
   reg [7:0] en_q [0:1];
   integer fail_count, comparisons, r, i;
   dee_error_reevaluate_bit_region #(.NUM_REGIONS(2)) dut_u (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_missed_event_low(mlo),
      .dma_missed_event_high(mhi), .qdma_missed_event(qmis),
      .controller_error_set(cset), .rgn_sel(rgn_sel), .dma_chan_rdata(crd),
      .dma_chan_wmask(cwm), .dma_gated_rdata(grd), .dma_gated_wmask(gwm),
      .qdma_chan_rdata(qrd), .qdma_chan_wmask(qwm), .qdma_gated_rdata(gqrd),
      .qdma_gated_wmask(gqwm), .dma_done_pending(pend),
      .dma_done_enable(dena), .rgn_done_irq(rdone), .err_irq_pulse(pulse),
      .irq(irq));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [63:0] gate(input [63:0] v, input integer s);
      gate = (s < 2) ? v & {en_hi[s], en_lo[s]} : 64'h0;
   endfunction
   function [7:0] qgate(input [7:0] v, input integer s);
      qgate = (s < 2) ? v & en_q[s] : 8'h00;
   endfunction
   task chk(input [63:0] seen, input [63:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         @(negedge clk);
         chk(reg_rdata, e);
      end
   endtask
   task end_sim;
      begin
         if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task tick;
      begin
         @(posedge clk);
         @(negedge clk);
      end
   endtask
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   initial begin
      #400000;
      fail_count = fail_count + 1;
      end_sim;
   end
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata, rgn_sel} = 1'b1 << 74;
      {mlo, mhi, qmis, cset, crd, cwm, qrd, qwm, pend, dena} = 0;
      fail_count = 0;
      comparisons = 0;
      t = $urandom(32'hcf406896);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (r = 0; r < 2; r++)
         for (i = 0; i < 4; i++)
            rd(8'(8'h10 + 4 * r + i), 0);
      for (r = 0; r < 2; r++) begin
         en_lo[r] = $urandom;
         en_hi[r] = r ? 32'h0000_0001 : $urandom;
         t = $urandom;
         en_q[r] = t[7:0];
         wr(8'(8'h10 + 4 * r), en_lo[r]);
         wr(8'(8'h11 + 4 * r), en_hi[r]);
         wr(8'(8'h12 + 4 * r), t);
         rd(8'(8'h10 + 4 * r), en_lo[r]);
         rd(8'(8'h11 + 4 * r), en_hi[r]);
         rd(8'(8'h12 + 4 * r), {24'h0, en_q[r]});
      end
      for (i = 0; i < 60; i++) begin
         @(posedge clk);
         rgn_sel <= i % 3;
         crd <= {$urandom, $urandom};
         cwm <= {$urandom, $urandom};
         qrd <= $urandom;
         qwm <= $urandom;
         pend <= 64'h1 << ($urandom % 64);
         dena <= {$urandom, $urandom};
         @(negedge clk);
         chk(grd, gate(crd, rgn_sel));
         chk(gwm, gate(cwm, rgn_sel));
         chk(gqrd, qgate(qrd, rgn_sel));
         chk(gqwm, qgate(qwm, rgn_sel));
         chk(rdone[0], |(pend & dena & gate('1, 0)));
         chk(rdone[1], |(pend & dena & gate('1, 1)));
      end
      wr(8'h04, 32'h0000_0003);
      @(posedge clk);
      mlo <= 32'h0000_0008;
      tick;
      chk({pulse, irq}, 2'b11);
      @(negedge clk);
      chk(pulse, 0);
      @(posedge clk);
      qmis <= 8'h80;
      tick;
      chk(pulse, 0);
      wr(8'h03, 32'h0000_0003);
      wr(8'h01, 32'h0000_0000);
      @(negedge clk);
      chk({pulse, irq}, 2'b00);
      wr(8'h01, 32'h0000_0001);
      @(negedge clk);
      chk({pulse, irq}, 2'b11);
      @(negedge clk);
      chk(pulse, 0);
      @(posedge clk);
      {mlo, qmis} <= 0;
      tick;
      @(posedge clk);
      mhi <= 32'h8000_0000;
      tick;
      chk(pulse, 1);
      @(posedge clk);
      mhi <= 0;
      tick;
      wr(8'h01, 32'h0000_0001);
      @(negedge clk);
      chk(pulse, 0);
      @(posedge clk);
      cset <= 17'h1_0020;
      @(posedge clk);
      cset <= 0;
      tick;
      chk(pulse, 1);
      rd(8'h03, 32'h0000_0003);
      rd(8'h04, 32'h0000_0003);
      rd(8'h05, 32'h0000_0001);
      wr(8'h03, 32'h0000_0003);
      rd(8'h03, 32'h0000_0000);
      chk(irq, 0);
      wr(8'h00, 32'h0000_0000);
      rd(8'h02, 32'h0001_0020);
      wr(8'h00, 32'h0000_0020);
      rd(8'h02, 32'h0001_0000);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h02, 32'h0000_0000);
      end_sim;
   end
endmodule

/* tb/dee_reevaluate_bit_region_asserts.sv */
// dee_reevaluate_bit_region_asserts.sv: port-level checker for the error evaluation
// and region enable block; attached by bind, sees only the block's ports.
`timescale 1ns/1ps
module dee_reevaluate_bit_chk #(
   parameter NUM_REGIONS = 8
) (
   input wire clk,
   input wire rst,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire [31:0] dma_missed_event_low,
   input wire [31:0] dma_missed_event_high,
   input wire [7:0] qdma_missed_event,
   input wire [16:0] controller_error_set,
   input wire [63:0] dma_chan_rdata,
   input wire [63:0] dma_chan_wmask,
   input wire [63:0] dma_gated_rdata,
   input wire [63:0] dma_gated_wmask,
   input wire [7:0] qdma_chan_rdata,
   input wire [7:0] qdma_gated_rdata,
   input wire [63:0] dma_done_pending,
   input wire [63:0] dma_done_enable,
   input wire [NUM_REGIONS-1:0] rgn_done_irq,
   input wire err_irq_pulse,
   input wire irq
);
   // ---------------------------------------------------------------
   // helpers and properties
   // ---------------------------------------------------------------
   // ctrl flags are one cycle later than the missed-event inputs
   wire any_mis = (|dma_missed_event_low) || (|dma_missed_event_high) ||
      (|qdma_missed_event);
   wire cerr_any = |controller_error_set;
   wire reevaluate_bit_wr = reg_wr && reg_addr == 8'h01 && reg_wdata[0];
   wire mask_wr = reg_wr && reg_addr == 8'h04;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_dma_rd_gate: assert property (
      (dma_gated_rdata & ~dma_chan_rdata) == 64'h0)
      else $error("gated dma read shows a clear bit");
   chk_dma_wr_gate: assert property (
      (dma_gated_wmask & ~dma_chan_wmask) == 64'h0)
      else $error("gated dma write mask exceeds request");
   chk_qdma_rd_gate: assert property (
      (qdma_gated_rdata & ~qdma_chan_rdata) == 8'h00)
      else $error("gated qdma read shows a clear bit");
   chk_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   chk_wo_read_zero: assert property (
      reg_rd && reg_addr <= 8'h01 |=> reg_rdata == 32'h0000_0000)
      else $error("write-only register read nonzero");
   chk_pulse_cause: assert property (
      err_irq_pulse |-> $past(reevaluate_bit_wr) || $past(any_mis) ||
      $past(cerr_any, 2))
      else $error("error pulse without a cause");
   chk_irq_cause: assert property (
      $rose(irq) |-> err_irq_pulse || $past(mask_wr))
      else $error("interrupt rose without event");
   chk_done_gate: assert property (
      rgn_done_irq != 0 |-> (dma_done_pending & dma_done_enable) != 0)
      else $error("completion irq without enabled pending");
   cover property (err_irq_pulse);
   cover property (reevaluate_bit_wr ##1 err_irq_pulse);
   cover property (rgn_done_irq != 0);
endmodule
bind dee_error_reevaluate_bit_region dee_reevaluate_bit_chk #(.NUM_REGIONS(NUM_REGIONS)) chk_u (.*);

/* verilog/dee_defs.vh */
// dee_defs.vh: register offsets, field positions and reset values for the
// error evaluation and region access enable block.
// assumes a word-indexed register port; definitions only, no logic.
`ifndef DEE_DEFS_VH
`define DEE_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (word address on the register port)
// ----------------------------------------------------------------------
`define DEE_ADDR_W 8
`define DEE_OFF_ERR_CLEAR 8'h00
`define DEE_OFF_ERR_REEVAL 8'h01
`define DEE_OFF_ERR_STATUS 8'h02
`define DEE_OFF_IRQ_STATUS 8'h03
`define DEE_OFF_IRQ_MASK 8'h04
`define DEE_OFF_ERR_SUMMARY 8'h05
`define DEE_OFF_RGN_BASE 8'h10
`define DEE_RGN_STRIDE 2
`define DEE_RGN_DMA_LOW 2'h0
`define DEE_RGN_DMA_HIGH 2'h1
`define DEE_RGN_QDMA 2'h2
`define DEE_RGN_UNUSED 2'h3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DEE_REEVAL_BIT 0
`define DEE_IRQ_W 2
`define DEE_IRQ_ERR_BIT 0
`define DEE_IRQ_REEVAL_BIT 1
`define DEE_QDMA_W 8
`define DEE_QDMA_MSB 7
`define DEE_CTRL_ERR_W 17

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DEE_RST_ENABLE 32'h0000_0000
`define DEE_RST_QDMA 8'h00
`define DEE_RST_IRQ 2'h0
`define DEE_ZERO32 32'h0000_0000

`endif

/* verilog/dee_error_reevaluate_bit_region.v */
// dee_error_reevaluate_bit_region.v: error interrupt evaluation, controller error
// flags with write-one-to-clear, and per-region dma/qdma access enables.
// assumes software on a simple strobe port; the error sources, the
// channel registers and their region windows live outside this block.
//
// How it works
// - any missed-event or controller error flag set raises the error interrupt.
// - later errors re-raise it only on a change from all clear to some set.
// - writing one to the reevaluate bit pulses the interrupt while any flag is set.
// - writing zero to the reevaluate bit changes neither interrupt nor flags.
// - each region has a low dma enable mask, channels 0 to 31 in bits 31-0.
// - each region has a high dma enable mask, channels 32 to 63 in bits 31-0.
// - a cleared dma enable reads the channel bit as zero and drops writes to it.
// - a cleared dma enable keeps that channel out of the region completion irq.
// - a set dma enable passes real reads and lets writes update the bit.
// - a set dma enable lets the channel's enabled completion bits reach the irq.
// - each region has a qdma enable mask gating qdma channel register bits.
// - the qdma mask holds eight enables in bits 7-0, gating reads and writes.
// - writing one to a controller error clear bit clears that flag, zero does not.
`timescale 1ns/1ps
`include "dee_defs.vh"

module dee_error_reevaluate_bit_region #(
   parameter NUM_REGIONS = 8
) (
   input wire clk,
   input wire rst,
   // register port
   input wire [`DEE_ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // error sources from the channel controller
   input wire [31:0] dma_missed_event_low,
   input wire [31:0] dma_missed_event_high,
   input wire [7:0] qdma_missed_event,
   input wire [`DEE_CTRL_ERR_W-1:0] controller_error_set,
   // shadow-region gating of dma channel registers
   input wire [31:0] rgn_sel,
   input wire [63:0] dma_chan_rdata,
   input wire [63:0] dma_chan_wmask,
   output wire [63:0] dma_gated_rdata,
   output wire [63:0] dma_gated_wmask,
   // shadow-region gating of qdma channel registers
   input wire [`DEE_QDMA_W-1:0] qdma_chan_rdata,
   input wire [`DEE_QDMA_W-1:0] qdma_chan_wmask,
   output wire [`DEE_QDMA_W-1:0] qdma_gated_rdata,
   output wire [`DEE_QDMA_W-1:0] qdma_gated_wmask,
   // completion interrupt sources, pending and enabled per channel
   input wire [63:0] dma_done_pending,
   input wire [63:0] dma_done_enable,
   output wire [NUM_REGIONS-1:0] rgn_done_irq,
   // outputs
   output reg err_irq_pulse,
   output wire irq
);

   // -------------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------------
   wire [32*NUM_REGIONS-1:0] en_low_bus;
   wire [32*NUM_REGIONS-1:0] en_high_bus;
   wire [`DEE_QDMA_W*NUM_REGIONS-1:0] en_qdma_bus;
   reg [`DEE_CTRL_ERR_W-1:0] ctrl_err_ff;
   reg any_err_d_ff;
   reg [`DEE_IRQ_W-1:0] irq_status_ff;
   reg [`DEE_IRQ_W-1:0] irq_mask_ff;

   // -------------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------------
   wire [`DEE_ADDR_W-1:0] rgn_off;
   wire [`DEE_ADDR_W-1:0] rgn_idx;
   wire [1:0] rgn_reg;
   wire rgn_hit;
   assign rgn_off = reg_addr - `DEE_OFF_RGN_BASE;
   assign rgn_idx = rgn_off >> `DEE_RGN_STRIDE;
   assign rgn_reg = rgn_off[1:0];
   assign rgn_hit = (reg_addr >= `DEE_OFF_RGN_BASE) &&
      (rgn_idx < NUM_REGIONS) && (rgn_reg != `DEE_RGN_UNUSED);

   wire wr_clear;
   wire wr_reeval;
   wire wr_irq_status;
   wire wr_irq_mask;
   assign wr_clear = reg_wr && (reg_addr == `DEE_OFF_ERR_CLEAR);
   assign wr_reeval = reg_wr && (reg_addr == `DEE_OFF_ERR_REEVAL);
   assign wr_irq_status = reg_wr && (reg_addr == `DEE_OFF_IRQ_STATUS);
   assign wr_irq_mask = reg_wr && (reg_addr == `DEE_OFF_IRQ_MASK);

   // -------------------------------------------------------------------
   // controller error flags
   // -------------------------------------------------------------------
   // set wins over a clear in the same cycle so no error is lost
   wire [`DEE_CTRL_ERR_W-1:0] nxt_ctrl_err;
   assign nxt_ctrl_err = (ctrl_err_ff &
      ~(wr_clear ? reg_wdata[`DEE_CTRL_ERR_W-1:0] :
      {`DEE_CTRL_ERR_W{1'b0}})) | controller_error_set;

   // -------------------------------------------------------------------
   // error interrupt evaluation
   // -------------------------------------------------------------------
   wire any_err;
   assign any_err = (|dma_missed_event_low) | (|dma_missed_event_high) |
      (|qdma_missed_event) | (|ctrl_err_ff);

   wire rise_err;
   wire reeval_hit;
   assign rise_err = any_err && !any_err_d_ff;
   // a zero in the reevaluate bit falls through with no effect; bit 1
   // is assumed written as zero by software and is ignored here
   assign reeval_hit = wr_reeval && reg_wdata[`DEE_REEVAL_BIT] &&
      any_err;

   wire nxt_err_irq_pulse;
   assign nxt_err_irq_pulse = rise_err | reeval_hit;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_err_ff <= {`DEE_CTRL_ERR_W{1'b0}};
      end else begin
         ctrl_err_ff <= nxt_ctrl_err;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         any_err_d_ff <= 1'b0;
         err_irq_pulse <= 1'b0;
      end else begin
         any_err_d_ff <= any_err;
         err_irq_pulse <= nxt_err_irq_pulse;
      end
   end

   // -------------------------------------------------------------------
   // interrupt status and mask
   // -------------------------------------------------------------------
   wire [`DEE_IRQ_W-1:0] irq_evt;
   assign irq_evt = {reeval_hit, rise_err};
   // an event wins over a clear of the same bit so none is lost
   wire [`DEE_IRQ_W-1:0] nxt_irq_status;
   assign nxt_irq_status = (irq_status_ff &
      ~(wr_irq_status ? reg_wdata[`DEE_IRQ_W-1:0] : `DEE_RST_IRQ)) |
      irq_evt;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status_ff <= `DEE_RST_IRQ;
      end else begin
         irq_status_ff <= nxt_irq_status;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask_ff <= `DEE_RST_IRQ;
      end else if (wr_irq_mask) begin
         irq_mask_ff <= reg_wdata[`DEE_IRQ_W-1:0];
      end
   end

   assign irq = |(irq_status_ff & irq_mask_ff);

   // -------------------------------------------------------------------
   // region access enable registers, one instance per region
   // -------------------------------------------------------------------
   wire [63:0] done_act;
   assign done_act = dma_done_pending & dma_done_enable;

   // each region decodes its own three words of the window
   genvar g;
   generate
      for (g = 0; g < NUM_REGIONS; g = g + 1) begin : g_rgn
         wire rgn_wr;
         wire wr_low;
         wire wr_high;
         wire wr_qdma;
         assign rgn_wr = reg_wr && rgn_hit && (rgn_idx == g);
         assign wr_low = rgn_wr && (rgn_reg == `DEE_RGN_DMA_LOW);
         assign wr_high = rgn_wr && (rgn_reg == `DEE_RGN_DMA_HIGH);
         assign wr_qdma = rgn_wr && (rgn_reg == `DEE_RGN_QDMA);
         dee_rgn_enable rgn_u (
            .clk(clk),
            .rst(rst),
            .wr_low(wr_low),
            .wr_high(wr_high),
            .wr_qdma(wr_qdma),
            .wdata(reg_wdata),
            .done_act(done_act),
            .en_low(en_low_bus[32*g +: 32]),
            .en_high(en_high_bus[32*g +: 32]),
            .en_qdma(en_qdma_bus[`DEE_QDMA_W*g +: `DEE_QDMA_W]),
            .done_irq(rgn_done_irq[g])
         );
      end
   endgenerate

   // -------------------------------------------------------------------
   // shadow-region gating
   // -------------------------------------------------------------------
   // rgn_sel is the region whose window is being accessed; an index past
   // the last region matches no entry, so every enable reads as zero
   reg [63:0] sel_dma_en;
   reg [`DEE_QDMA_W-1:0] sel_qdma_en;
   integer s;
   always @* begin
      sel_dma_en = {`DEE_ZERO32, `DEE_ZERO32};
      sel_qdma_en = `DEE_RST_QDMA;
      for (s = 0; s < NUM_REGIONS; s = s + 1) begin
         if (rgn_sel == s) begin
            sel_dma_en = {en_high_bus[32*s +: 32], en_low_bus[32*s +: 32]};
            sel_qdma_en = en_qdma_bus[`DEE_QDMA_W*s +: `DEE_QDMA_W];
         end
      end
   end

   assign dma_gated_rdata = dma_chan_rdata & sel_dma_en;
   assign dma_gated_wmask = dma_chan_wmask & sel_dma_en;
   assign qdma_gated_rdata = qdma_chan_rdata & sel_qdma_en;
   assign qdma_gated_wmask = qdma_chan_wmask & sel_qdma_en;

   // -------------------------------------------------------------------
   // addressed region enables for read back
   // -------------------------------------------------------------------
   reg [31:0] idx_low;
   reg [31:0] idx_high;
   reg [`DEE_QDMA_W-1:0] idx_qdma;
   integer k;
   always @* begin
      idx_low = `DEE_ZERO32;
      idx_high = `DEE_ZERO32;
      idx_qdma = `DEE_RST_QDMA;
      for (k = 0; k < NUM_REGIONS; k = k + 1) begin
         if (rgn_idx == k) begin
            idx_low = en_low_bus[32*k +: 32];
            idx_high = en_high_bus[32*k +: 32];
            idx_qdma = en_qdma_bus[`DEE_QDMA_W*k +: `DEE_QDMA_W];
         end
      end
   end

   // -------------------------------------------------------------------
   // read back, data one cycle after the strobe
   // -------------------------------------------------------------------
   reg [31:0] nxt_reg_rdata;
   always @* begin
      nxt_reg_rdata = `DEE_ZERO32;
      if (rgn_hit) begin
         case (rgn_reg)
            `DEE_RGN_DMA_LOW: nxt_reg_rdata = idx_low;
            `DEE_RGN_DMA_HIGH: nxt_reg_rdata = idx_high;
            `DEE_RGN_QDMA: nxt_reg_rdata[`DEE_QDMA_MSB:0] =
               idx_qdma;
            default: nxt_reg_rdata = `DEE_ZERO32;
         endcase
      end else begin
         case (reg_addr)
            `DEE_OFF_ERR_STATUS:
               nxt_reg_rdata[`DEE_CTRL_ERR_W-1:0] = ctrl_err_ff;
            `DEE_OFF_IRQ_STATUS:
               nxt_reg_rdata[`DEE_IRQ_W-1:0] = irq_status_ff;
            `DEE_OFF_IRQ_MASK:
               nxt_reg_rdata[`DEE_IRQ_W-1:0] = irq_mask_ff;
            `DEE_OFF_ERR_SUMMARY:
               nxt_reg_rdata[0] = any_err;
            // clear and reevaluate are write only and read as zero
            default: nxt_reg_rdata = `DEE_ZERO32;
         endcase
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= `DEE_ZERO32;
      end else if (reg_rd) begin
         reg_rdata <= nxt_reg_rdata;
      end else begin
         reg_rdata <= `DEE_ZERO32;
      end
   end

endmodule

// ----------------------------------------------------------------------
// one region: dma low/high and qdma access enables, completion irq
// ----------------------------------------------------------------------
module dee_rgn_enable (
   input wire clk,
   input wire rst,
   input wire wr_low,
   input wire wr_high,
   input wire wr_qdma,
   input wire [31:0] wdata,
   input wire [63:0] done_act,
   output wire [31:0] en_low,
   output wire [31:0] en_high,
   output wire [`DEE_QDMA_W-1:0] en_qdma,
   output wire done_irq
);

   reg [31:0] en_low_ff;
   reg [31:0] en_high_ff;
   reg [`DEE_QDMA_W-1:0] en_qdma_ff;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         en_low_ff <= `DEE_RST_ENABLE;
      end else if (wr_low) begin
         en_low_ff <= wdata;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         en_high_ff <= `DEE_RST_ENABLE;
      end else if (wr_high) begin
         en_high_ff <= wdata;
      end
   end

   // bits above the eight qdma channels are dropped on write
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         en_qdma_ff <= `DEE_RST_QDMA;
      end else if (wr_qdma) begin
         en_qdma_ff <= wdata[`DEE_QDMA_MSB:0];
      end
   end

   assign en_low = en_low_ff;
   assign en_high = en_high_ff;
   assign en_qdma = en_qdma_ff;

   // a cleared enable keeps the channel out of this region's irq
   assign done_irq = |(done_act &
      {en_high_ff, en_low_ff});

endmodule
